// ---- hw/mmct_pkg.sv ----
package mmct_pkg;
  // ----------------------------------------------------------------
  // Byte offsets on the management bus
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS   = 8'h02;
  localparam logic [7:0] OFS_FLAG_LN  = 8'h03;
  localparam logic [7:0] OFS_FLAG_MOD = 8'h04;
  localparam logic [7:0] OFS_PWR_CTL  = 8'h5D;
  localparam logic [7:0] OFS_CDR      = 8'h62;
  localparam logic [7:0] OFS_MASK_LN  = 8'h64;
  localparam logic [7:0] OFS_MASK_MOD = 8'h65;
  localparam logic [7:0] OFS_EQ       = 8'hEA;
  localparam logic [7:0] OFS_EMPH     = 8'hEC;
  localparam logic [7:0] OFS_AMP      = 8'hEE;

  // ----------------------------------------------------------------
  // Field positions and legal code limits
  // ----------------------------------------------------------------
  localparam int         BIT_NOT_READY = 0;
  localparam int         BIT_PDOWN     = 0;
  localparam int         BIT_AUX_FLAG  = 0;
  localparam int         BIT_INIT_FLAG = 1;
  localparam logic [3:0] EQ_MAX        = 4'hA;
  localparam logic [3:0] EMPH_MAX      = 4'h7;
  localparam logic [3:0] AMP_MAX       = 4'h3;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0]  CDR_RST  = 8'hFF;
  localparam logic [15:0] CODE_RST = 16'h0000;
  localparam logic [7:0]  MASK_RST = 8'h00;
  // Pin idle levels: clock, data, select and reset high, rest low
  localparam logic [13:0] PIN_IDLE = 14'h3C00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLK_PERIOD_NS  = 10;
  localparam longint T_INIT_MS      = 2000;
  localparam longint INIT_CYC       =
    (T_INIT_MS * 1000000) / CLK_PERIOD_NS;
  localparam longint T_RST_PULSE_NS = 2000;
  // Half the pulse, so a legal pulse is seen well inside its length
  localparam logic [7:0] RST_FILT_CYC =
    8'((T_RST_PULSE_NS / CLK_PERIOD_NS) / 2);

  // ----------------------------------------------------------------
  // Serial bus engine states
  // ----------------------------------------------------------------
  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_ADDR  = 9'h002,
    ST_ACK_A = 9'h004,
    ST_OFS   = 9'h008,
    ST_ACK_O = 9'h010,
    ST_WDAT  = 9'h020,
    ST_ACK_D = 9'h040,
    ST_RDAT  = 9'h080,
    ST_RACK  = 9'h100
  } mmct_bus_st_t;
endpackage : mmct_pkg

// ---- hw/mmct_sync.sv ----
`timescale 1ns/1ns
module mmct_sync #(
  parameter int           W     = 1,
  parameter logic [W-1:0] P_RST = '1
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_srst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second
  // Reset to idle levels, so no false edge or flag follows reset
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      meta_q <= P_RST;
      o_q    <= P_RST;
    end else begin
      meta_q <= i_d;
      o_q    <= meta_q;
    end
  end
endmodule : mmct_sync

// ---- hw/mmct_top.sv ----
// Contract
// - One retimer enable bit per lane
// - Amplitude codes 0-3 valid, rest reserved
// - Equalization codes 0-10 dB valid
// - Emphasis codes 0-7 dB valid
// - Fully functional within 2000 ms after start
// - Reset pin low 2 us is recognized
// - Bus answers within 2000 ms of power
// - Clear not-ready bit and raise interrupt
// - Functional within 2000 ms after reset release
// - Low power pin lowers power quickly
// - Interrupt asserted within 200 ms of cause
// - Flag read clears, interrupt released quickly
// - Loss of signal flags within 100 ms
// - Transmit fault flags within 200 ms
// - Other conditions flag within 200 ms
// - Setting mask stops interrupt within 100 ms
// - Clearing mask resumes interrupt within 100 ms
// - Selected module answers bus within 100 us
// - Deselected module stops answering bus
// - Power-down bit lowers power within 100 ms
// - Clearing power-down restores function within 300 ms
`timescale 1ns/1ns
module mmct_top #(
  parameter logic [6:0]  P_DEV_ADDR = 7'h50,
  parameter logic [27:0] P_INIT_CYC = 28'(mmct_pkg::INIT_CYC)
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_srst,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda,
  output logic             o_sda_oe,
  input  wire logic        i_module_select_n,
  input  wire logic        i_module_reset_n,
  input  wire logic        i_low_power_pin,
  input  wire logic [3:0]  i_rx_los,
  input  wire logic [3:0]  i_tx_fault,
  input  wire logic        i_aux_cond,
  output logic             o_irq_n,
  output logic [3:0]       o_tx_retimer_on,
  output logic [3:0]       o_rx_retimer_on,
  output logic [15:0]      o_tx_eq_code,
  output logic [15:0]      o_rx_emph_code,
  output logic [15:0]      o_rx_amp_code,
  output logic             o_low_power
);
  import mmct_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [13:0]  raw_pins;
  logic [13:0]  syn_pins;
  logic         scl_s;
  logic         sda_s;
  logic         sel_n_s;
  logic         rst_n_s;
  logic         lp_s;
  logic [3:0]   los_s;
  logic [3:0]   flt_s;
  logic         aux_s;

  assign raw_pins = {i_scl, i_sda, i_module_select_n, i_module_reset_n,
                     i_low_power_pin, i_rx_los, i_tx_fault, i_aux_cond};

  mmct_sync #(.W(14), .P_RST(PIN_IDLE)) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_d       (raw_pins),
    .o_q       (syn_pins)
  );

  assign {scl_s, sda_s, sel_n_s, rst_n_s, lp_s, los_s, flt_s, aux_s} =
    syn_pins;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  // ----------------------------------------------------------------
  // Module reset pin and initialization
  // ----------------------------------------------------------------
  logic [7:0]   rst_cnt_q;
  logic         mod_rst_q;
  logic         blk_rst;
  logic [27:0]  init_cnt_q;
  logic         ready_q;
  logic         init_evt;

  // Short glitches are filtered; release takes effect at once
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      rst_cnt_q <= 8'h00;
      mod_rst_q <= 1'b1;
    end else if (rst_n_s) begin
      rst_cnt_q <= 8'h00;
      mod_rst_q <= 1'b0;
    end else if (rst_cnt_q == RST_FILT_CYC) begin
      mod_rst_q <= 1'b1;
    end else begin
      rst_cnt_q <= rst_cnt_q + 8'h01;
    end
  end

  AST_RST_PULSE: assert property (
    (!rst_n_s && rst_cnt_q == RST_FILT_CYC) |=> mod_rst_q)
    else $error("reset pin low not recognized");

  assign blk_rst  = i_srst || mod_rst_q;
  assign init_evt = !blk_rst && !ready_q &&
                    init_cnt_q == P_INIT_CYC - 28'd1;

  always_ff @(posedge i_clk_sys) begin
    if (blk_rst) begin
      init_cnt_q <= 28'd0;
      ready_q    <= 1'b0;
    end else if (!ready_q) begin
      if (init_evt) begin
        ready_q <= 1'b1;
      end else begin
        init_cnt_q <= init_cnt_q + 28'd1;
      end
    end
  end

  AST_INIT_BOUND: assert property (
    !ready_q |-> init_cnt_q < P_INIT_CYC)
    else $error("initialization overran its limit");

  // ----------------------------------------------------------------
  // Serial bus engine
  // ----------------------------------------------------------------
  mmct_bus_st_t st_q;
  logic         scl_d1_q;
  logic         sda_d1_q;
  logic [3:0]   cnt_q;
  logic [7:0]   sh_q;
  logic [7:0]   tx_q;
  logic [7:0]   ptr_q;
  logic         rw_q;
  logic         nack_q;
  logic         oe_q;
  logic         sda_o_q;
  logic         active;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_c;
  logic         stop_c;
  logic         step;
  logic         wr_stb;
  logic         rd_stb;
  logic [7:0]   rd_byte;

  // Bus answers only while selected, from reset release onward
  assign active   = !sel_n_s && !mod_rst_q;
  assign scl_rise = scl_s && !scl_d1_q;
  assign scl_fall = !scl_s && scl_d1_q;
  assign start_c  = scl_s && scl_d1_q && sda_d1_q && !sda_s;
  assign stop_c   = scl_s && scl_d1_q && !sda_d1_q && sda_s;
  assign step     = active && !start_c && !stop_c && scl_fall;
  assign wr_stb   = step && st_q == ST_WDAT && cnt_q == 4'd8;
  assign rd_stb   = step && ((st_q == ST_ACK_A && rw_q) ||
                             (st_q == ST_RACK && !nack_q));

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
      sda_o_q  <= 1'b0;
    end else begin
      scl_d1_q <= scl_s;
      sda_d1_q <= sda_s;
      sda_o_q  <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      st_q   <= ST_IDLE;
      oe_q   <= 1'b0;
      cnt_q  <= 4'd0;
      sh_q   <= 8'h00;
      tx_q   <= 8'h00;
      ptr_q  <= 8'h00;
      rw_q   <= 1'b0;
      nack_q <= 1'b0;
    end else if (!active || stop_c) begin
      st_q  <= ST_IDLE;
      oe_q  <= 1'b0;
      cnt_q <= 4'd0;
    end else if (start_c) begin
      st_q  <= ST_ADDR;
      oe_q  <= 1'b0;
      cnt_q <= 4'd0;
    end else if (scl_rise) begin
      if (st_q == ST_RACK) begin
        nack_q <= sda_s;
      end else begin
        sh_q  <= {sh_q[6:0], sda_s};
        cnt_q <= cnt_q + 4'd1;
      end
    end else if (scl_fall) begin
      unique case (st_q)
        ST_IDLE: begin
        end
        ST_ADDR: begin
          if (cnt_q == 4'd8) begin
            if (sh_q[7:1] == P_DEV_ADDR) begin
              oe_q <= 1'b1;
              rw_q <= sh_q[0];
              st_q <= ST_ACK_A;
            end else begin
              st_q <= ST_IDLE;
            end
          end
        end
        ST_ACK_A: begin
          cnt_q <= 4'd0;
          if (rw_q) begin
            tx_q  <= rd_byte;
            oe_q  <= !rd_byte[7];
            ptr_q <= ptr_q + 8'h01;
            st_q  <= ST_RDAT;
          end else begin
            oe_q <= 1'b0;
            st_q <= ST_OFS;
          end
        end
        ST_OFS: begin
          if (cnt_q == 4'd8) begin
            oe_q  <= 1'b1;
            ptr_q <= sh_q;
            st_q  <= ST_ACK_O;
          end
        end
        ST_ACK_O, ST_ACK_D: begin
          oe_q  <= 1'b0;
          cnt_q <= 4'd0;
          st_q  <= ST_WDAT;
        end
        ST_WDAT: begin
          if (cnt_q == 4'd8) begin
            oe_q  <= 1'b1;
            ptr_q <= ptr_q + 8'h01;
            st_q  <= ST_ACK_D;
          end
        end
        ST_RDAT: begin
          if (cnt_q == 4'd8) begin
            oe_q <= 1'b0;
            st_q <= ST_RACK;
          end else begin
            oe_q <= !tx_q[6];
            tx_q <= {tx_q[6:0], 1'b0};
          end
        end
        ST_RACK: begin
          if (nack_q) begin
            st_q <= ST_IDLE;
          end else begin
            cnt_q <= 4'd0;
            tx_q  <= rd_byte;
            oe_q  <= !rd_byte[7];
            ptr_q <= ptr_q + 8'h01;
            st_q  <= ST_RDAT;
          end
        end
      endcase
    end
  end

  AST_DESELECT: assert property (
    !active |=> (st_q == ST_IDLE && !o_sda_oe))
    else $error("bus engine active while not selected");

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [7:0]   cdr_q;
  logic [15:0]  eq_q;
  logic [15:0]  emph_q;
  logic [15:0]  amp_q;
  logic         pdown_q;
  logic [7:0]   mask_ln_q;
  logic [1:0]   mask_mod_q;

  // Reserved nibbles leave the lane's previous code in place
  function automatic logic [7:0] keep_legal(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic [3:0] max_v);
    logic [7:0] res;
    res = old_v;
    for (int i = 0; i < 2; i++) begin
      if (new_v[i*4 +: 4] <= max_v) begin
        res[i*4 +: 4] = new_v[i*4 +: 4];
      end
    end
    return res;
  endfunction : keep_legal

  // Lane 1 sits in the top nibble of each code word
  always_ff @(posedge i_clk_sys) begin
    if (blk_rst) begin
      cdr_q      <= CDR_RST;
      eq_q       <= CODE_RST;
      emph_q     <= CODE_RST;
      amp_q      <= CODE_RST;
      pdown_q    <= 1'b0;
      mask_ln_q  <= MASK_RST;
      mask_mod_q <= MASK_RST[1:0];
    end else if (wr_stb) begin
      case (ptr_q)
        OFS_CDR:          cdr_q <= sh_q;
        OFS_EQ:           eq_q[15:8] <= keep_legal(eq_q[15:8], sh_q,
                                                   EQ_MAX);
        OFS_EQ + 8'h01:   eq_q[7:0] <= keep_legal(eq_q[7:0], sh_q,
                                                  EQ_MAX);
        OFS_EMPH:         emph_q[15:8] <= keep_legal(emph_q[15:8],
                                                     sh_q, EMPH_MAX);
        OFS_EMPH + 8'h01: emph_q[7:0] <= keep_legal(emph_q[7:0], sh_q,
                                                    EMPH_MAX);
        OFS_AMP:          amp_q[15:8] <= keep_legal(amp_q[15:8], sh_q,
                                                    AMP_MAX);
        OFS_AMP + 8'h01:  amp_q[7:0] <= keep_legal(amp_q[7:0], sh_q,
                                                   AMP_MAX);
        OFS_PWR_CTL:      pdown_q <= sh_q[BIT_PDOWN];
        OFS_MASK_LN:      mask_ln_q <= sh_q;
        OFS_MASK_MOD:     mask_mod_q <= sh_q[1:0];
        default: begin
        end
      endcase
    end
  end

  AST_CDR_WRITE: assert property (
    (wr_stb && ptr_q == OFS_CDR) |=> ##1
      ({o_tx_retimer_on, o_rx_retimer_on} == $past(sh_q, 2)))
    else $error("retimer enables do not follow write");

  AST_AMP_RESERVED: assert property (
    (wr_stb && ptr_q == OFS_AMP && sh_q[7:4] > AMP_MAX)
      |=> amp_q[15:12] == $past(amp_q[15:12]))
    else $error("reserved amplitude code was applied");

  AST_EQ_LEGAL: assert property (
    (wr_stb && ptr_q == OFS_EQ && sh_q[7:4] <= EQ_MAX)
      |=> ##1 o_tx_eq_code[15:12] == $past(sh_q[7:4], 2))
    else $error("legal equalization code not applied");

  AST_EMPH_RESERVED: assert property (
    (wr_stb && ptr_q == OFS_EMPH + 8'h01 && sh_q[3:0] > EMPH_MAX)
      |=> emph_q[3:0] == $past(emph_q[3:0]))
    else $error("reserved emphasis code was applied");

  // ----------------------------------------------------------------
  // Flags, read mux and interrupt
  // ----------------------------------------------------------------
  logic [7:0]   flag_ln_q;
  logic [1:0]   flag_mod_q;
  logic [7:0]   set_ln;
  logic [1:0]   set_mod;
  logic         clr_ln;
  logic         clr_mod;

  assign set_ln  = {flt_s, los_s};
  assign set_mod = {init_evt, aux_s};
  assign clr_ln  = rd_stb && ptr_q == OFS_FLAG_LN;
  assign clr_mod = rd_stb && ptr_q == OFS_FLAG_MOD;

  // A condition present at the clearing read keeps its flag set
  always_ff @(posedge i_clk_sys) begin
    if (blk_rst) begin
      flag_ln_q  <= 8'h00;
      flag_mod_q <= 2'b00;
    end else begin
      flag_ln_q  <= set_ln | (clr_ln ? 8'h00 : flag_ln_q);
      flag_mod_q <= set_mod | (clr_mod ? 2'b00 : flag_mod_q);
    end
  end

  always_comb begin
    case (ptr_q)
      OFS_STATUS:       rd_byte = {7'h00, !ready_q};
      OFS_FLAG_LN:      rd_byte = flag_ln_q;
      OFS_FLAG_MOD:     rd_byte = {6'h00, flag_mod_q};
      OFS_PWR_CTL:      rd_byte = {7'h00, pdown_q};
      OFS_CDR:          rd_byte = cdr_q;
      OFS_MASK_LN:      rd_byte = mask_ln_q;
      OFS_MASK_MOD:     rd_byte = {6'h00, mask_mod_q};
      OFS_EQ:           rd_byte = eq_q[15:8];
      OFS_EQ + 8'h01:   rd_byte = eq_q[7:0];
      OFS_EMPH:         rd_byte = emph_q[15:8];
      OFS_EMPH + 8'h01: rd_byte = emph_q[7:0];
      OFS_AMP:          rd_byte = amp_q[15:8];
      OFS_AMP + 8'h01:  rd_byte = amp_q[7:0];
      default:          rd_byte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (blk_rst) begin
      o_irq_n     <= 1'b1;
      o_low_power <= 1'b0;
    end else begin
      o_irq_n     <= !(|(flag_ln_q & ~mask_ln_q) ||
                       |(flag_mod_q & ~mask_mod_q));
      o_low_power <= lp_s || pdown_q;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    o_tx_retimer_on <= cdr_q[7:4];
    o_rx_retimer_on <= cdr_q[3:0];
    o_tx_eq_code    <= eq_q;
    o_rx_emph_code  <= emph_q;
    o_rx_amp_code   <= amp_q;
  end

  assign o_sda    = sda_o_q;
  assign o_sda_oe = oe_q;

  sequence s_los_unmasked;
    los_s[0] && !mask_ln_q[0] && !wr_stb && !blk_rst;
  endsequence

  sequence s_irq_low;
    ##[1:2] !o_irq_n;
  endsequence

  AST_LOS_IRQ: assert property (
    s_los_unmasked |-> s_irq_low)
    else $error("loss of signal did not raise interrupt");

  AST_FAULT_FLAG: assert property (
    (flt_s[2] && !blk_rst) |=> flag_ln_q[6])
    else $error("transmit fault flag not set");

  AST_INIT_IRQ: assert property (
    init_evt && !mask_mod_q[BIT_INIT_FLAG] && !wr_stb
      |=> ready_q ##1 !o_irq_n)
    else $error("ready event did not raise interrupt");

  AST_CLEAR_ON_READ: assert property (
    (clr_ln && set_ln == 8'h00 && !blk_rst) |=> flag_ln_q == 8'h00)
    else $error("flag read did not clear flags");

  AST_MASK_GATES: assert property (
    ((flag_ln_q & ~mask_ln_q) == 8'h00 &&
     (flag_mod_q & ~mask_mod_q) == 2'b00 && !blk_rst) |=> o_irq_n)
    else $error("interrupt held with no unmasked flag");

  AST_LOW_POWER: assert property (
    (lp_s || pdown_q) && !blk_rst |=> o_low_power)
    else $error("low power request not applied");

  AST_POWER_RESTORE: assert property (
    (!lp_s && !pdown_q && !blk_rst) |=> !o_low_power)
    else $error("full power not restored");
endmodule : mmct_top

// ---- verification/mmct_host_bfm.sv ----
`timescale 1ns/1ns
module mmct_host_bfm #(
  parameter logic [6:0] P_ADDR = 7'h50,
  parameter int         P_HALF = 20
) (
  input  wire logic i_clk_sys,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_oe
);
  // ------------------------------------------------------------
  // Bus phases
  // ------------------------------------------------------------
  // SCL stands high between frames; phases far above sync delay
  initial begin
    o_scl    = 1'h1;
    o_sda_oe = 1'h0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask : tick

  task automatic start_cond;
    o_sda_oe = 1'h0;
    tick(P_HALF / 2);
    o_scl = 1'h1;
    tick(P_HALF);
    o_sda_oe = 1'h1;
    tick(P_HALF);
    o_scl = 1'h0;
    tick(P_HALF / 2);
  endtask : start_cond

  task automatic stop_cond;
    o_sda_oe = 1'h1;
    tick(P_HALF / 2);
    o_scl = 1'h1;
    tick(P_HALF);
    o_sda_oe = 1'h0;
    tick(P_HALF);
  endtask : stop_cond

  // Data moves mid-low, sampled just before SCL falls
  task automatic bit_io(input logic b, output logic r);
    o_sda_oe = ~b;
    tick(P_HALF / 2);
    o_scl = 1'h1;
    tick(P_HALF);
    r = i_sda;
    o_scl = 1'h0;
    tick(P_HALF / 2);
  endtask : bit_io

  task automatic byte_io(input logic [7:0] tx, input logic ack_b,
                         output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ack_b, r);
    ack = ~r;
  endtask : byte_io

  task automatic wr(input logic [7:0] ofs, input logic [15:0] d,
                    input int n, output logic ok);
    logic [7:0] rx;
    logic       a0, a1, a2, a3;
    start_cond;
    byte_io({P_ADDR, 1'h0}, 1'h1, rx, a0);
    byte_io(ofs, 1'h1, rx, a1);
    a2 = 1'h1;
    if (n == 2) begin
      byte_io(d[15:8], 1'h1, rx, a2);
    end
    byte_io(d[7:0], 1'h1, rx, a3);
    stop_cond;
    ok = a0 & a1 & a2 & a3;
  endtask : wr

  // Single byte read, closed by NACK then stop
  task automatic rd(input logic [7:0] ofs, output logic [7:0] d,
                    output logic ok);
    logic [7:0] rx;
    logic       a0, a1, a2, na;
    start_cond;
    byte_io({P_ADDR, 1'h0}, 1'h1, rx, a0);
    byte_io(ofs, 1'h1, rx, a1);
    start_cond;
    byte_io({P_ADDR, 1'h1}, 1'h1, rx, a2);
    byte_io(8'hFF, 1'h1, d, na);
    stop_cond;
    ok = a0 & a1 & a2;
  endtask : rd
endmodule : mmct_host_bfm

// ---- verification/test_module_mgmt_control_timing.sv ----
`timescale 1ns/1ns
module test_module_mgmt_control_timing;
  import mmct_pkg::*;
  // ------------------------------------------------------------
  // Setup
  // ------------------------------------------------------------
  // Short init count keeps the run inside the cycle budget
  localparam logic [27:0] INIT = 28'h0000FA0;
  localparam logic [6:0]  ADDR = 7'h50;
  logic        clk_sys = 1'h0;
  logic        srst = 1'h1;
  logic        sel_n = 1'h0;
  logic        mrst_n = 1'h1;
  logic        lp_pin = 1'h0;
  logic        aux = 1'h0;
  logic [3:0]  los = 4'h0;
  logic [3:0]  fault = 4'h0;
  logic        scl, h_oe, d_sda, d_oe, irq_n, low_pw, sda, ok;
  logic [3:0]  txr, rxr;
  logic [15:0] eq, em, am;
  logic [7:0]  rd;
  int          err_total = 0;
  int          samples_checked = 0;

  // Open drain with pull-up
  assign sda = ~h_oe & (d_oe ? d_sda : 1'h1);
  always #5 clk_sys = ~clk_sys;

  mmct_top #(.P_DEV_ADDR(ADDR), .P_INIT_CYC(INIT)) uut (
    .i_clk_sys(clk_sys), .i_srst(srst), .i_scl(scl), .i_sda(sda),
    .o_sda(d_sda), .o_sda_oe(d_oe), .i_module_select_n(sel_n),
    .i_module_reset_n(mrst_n), .i_low_power_pin(lp_pin),
    .i_rx_los(los), .i_tx_fault(fault), .i_aux_cond(aux),
    .o_irq_n(irq_n), .o_tx_retimer_on(txr), .o_rx_retimer_on(rxr),
    .o_tx_eq_code(eq), .o_rx_emph_code(em), .o_rx_amp_code(am),
    .o_low_power(low_pw));

  mmct_host_bfm #(.P_ADDR(ADDR), .P_HALF(4)) host (
    .i_clk_sys(clk_sys), .i_sda(sda), .o_scl(scl), .o_sda_oe(h_oe));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] got,
                     input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  // Bounded poll of irq_n (sel 0) or low power (sel 1)
  task automatic wait_out(input int sel, input logic v, input int lim,
                          input string nm);
    logic s;
    s = (sel == 0) ? irq_n : low_pw;
    for (int n = 0; n < lim && s !== v; n++) begin
      @(negedge clk_sys);
      s = (sel == 0) ? irq_n : low_pw;
    end
    chk(nm, 16'(s), 16'(v));
    if (s !== v) begin
      stop_test;
    end
  endtask : wait_out

  task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp,
                        input string nm, input logic [7:0] m = 8'hFF);
    host.rd(ofs, rd, ok);
    chk(nm, 16'(rd & m), 16'(exp));
  endtask : rd_chk

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_init;
    rd_chk(OFS_STATUS, 8'h01, "not_ready", 8'h01);
    chk("ack_init", 16'(ok), 16'h0001);
    chk("irq_init", 16'(irq_n), 16'h0001);
    chk("cdr_rst", {8'h00, txr, rxr}, 16'(CDR_RST));
    wait_out(0, 1'h0, 4200, "irq_ready");
    rd_chk(OFS_STATUS, 8'h00, "ready", 8'h01);
    rd_chk(OFS_FLAG_MOD, 8'h02, "init_flag");
    wait_out(0, 1'h1, 100, "irq_off");
    $display("t_init done");
  endtask : t_init

  task automatic t_cdr;
    host.wr(OFS_CDR, 16'h005A, 1, ok);
    chk("wr_ack", 16'(ok), 16'h0001);
    chk("cdr_out", {8'h00, txr, rxr}, 16'h005A);
    rd_chk(OFS_CDR, 8'h5A, "cdr_rd");
    $display("t_cdr done");
  endtask : t_cdr

  // Code 1, legal top code, first reserved code, all-ones, then mixed byte
  task automatic t_codes;
    logic [3:0]  mx, v;
    logic [7:0]  ofs;
    logic [15:0] exp, cv;
    for (int r = 0; r < 3; r++) begin
      mx = (r == 0) ? EQ_MAX : (r == 1) ? EMPH_MAX : AMP_MAX;
      ofs = (r == 0) ? OFS_EQ : (r == 1) ? OFS_EMPH : OFS_AMP;
      exp = CODE_RST;
      for (int k = 0; k < 4; k++) begin
        v = (k == 0) ? 4'h1 : (k == 1) ? mx : (k == 2) ? mx + 4'h1 : 4'hF;
        host.wr(ofs, {4{v}}, 2, ok);
        exp = (v <= mx) ? {4{v}} : exp;
        cv = (r == 0) ? eq : (r == 1) ? em : am;
        chk("code", cv, exp);
      end
      host.wr(ofs, {4'h0, mx + 4'h1, 4'h0, 4'hF}, 2, ok);
      exp = {4'h0, exp[11:8], 4'h0, exp[3:0]};
      cv = (r == 0) ? eq : (r == 1) ? em : am;
      chk("code_mix", cv, exp);
    end
    $display("t_codes done");
  endtask : t_codes

  task automatic t_flags;
    logic [7:0] fo, fe;
    for (int k = 0; k < 3; k++) begin
      los[1] = (k == 0);
      fault[2] = (k == 1);
      aux = (k == 2);
      fo = (k == 2) ? OFS_FLAG_MOD : OFS_FLAG_LN;
      fe = (k == 0) ? 8'h02 : (k == 1) ? 8'h40 : 8'h01;
      wait_out(0, 1'h0, 50, "irq_flag");
      los = 4'h0;
      fault = 4'h0;
      aux = 1'h0;
      rd_chk(fo, fe, "flag");
      wait_out(0, 1'h1, 100, "irq_clr");
      rd_chk(fo, 8'h00, "gone");
    end
    $display("t_flags done");
  endtask : t_flags

  task automatic t_mask;
    los[0] = 1'h1;
    wait_out(0, 1'h0, 50, "irq_los");
    host.wr(OFS_MASK_LN, 16'h0001, 1, ok);
    wait_out(0, 1'h1, 50, "irq_masked");
    host.wr(OFS_MASK_LN, 16'h0000, 1, ok);
    wait_out(0, 1'h0, 50, "irq_unmask");
    los[0] = 1'h0;
    rd_chk(OFS_FLAG_LN, 8'h01, "mask_flag");
    wait_out(0, 1'h1, 100, "irq_clr2");
    host.wr(OFS_MASK_MOD, 16'h0001, 1, ok);
    aux = 1'h1;
    repeat (20) @(negedge clk_sys);
    chk("aux_masked", 16'(irq_n), 16'h0001);
    aux = 1'h0;
    rd_chk(OFS_FLAG_MOD, 8'h01, "aux_flag");
    host.wr(OFS_MASK_MOD, 16'h0000, 1, ok);
    rd_chk(OFS_MASK_MOD, 8'h00, "mask_mod");
    $display("t_mask done");
  endtask : t_mask

  task automatic t_power;
    lp_pin = 1'h1;
    wait_out(1, 1'h1, 20, "lp_on");
    lp_pin = 1'h0;
    wait_out(1, 1'h0, 20, "lp_off");
    host.wr(OFS_PWR_CTL, 16'h0001, 1, ok);
    wait_out(1, 1'h1, 20, "pd_on");
    host.wr(OFS_PWR_CTL, 16'h0000, 1, ok);
    wait_out(1, 1'h0, 20, "pd_off");
    $display("t_power done");
  endtask : t_power

  task automatic t_select;
    sel_n = 1'h1;
    repeat (10) @(negedge clk_sys);
    host.rd(OFS_CDR, rd, ok);
    chk("desel_ack", 16'(ok), 16'h0000);
    sel_n = 1'h0;
    repeat (10) @(negedge clk_sys);
    rd_chk(OFS_CDR, 8'h5A, "sel_rd");
    chk("sel_ack", 16'(ok), 16'h0001);
    $display("t_select done");
  endtask : t_select

  // Short glitch must be ignored, a 2 us low must reset
  task automatic t_modrst;
    mrst_n = 1'h0;
    repeat (50) @(negedge clk_sys);
    mrst_n = 1'h1;
    repeat (10) @(negedge clk_sys);
    chk("short_rst", {8'h00, txr, rxr}, 16'h005A);
    mrst_n = 1'h0;
    repeat (200) @(negedge clk_sys);
    mrst_n = 1'h1;
    repeat (10) @(negedge clk_sys);
    chk("rst_cdr", {8'h00, txr, rxr}, 16'(CDR_RST));
    rd_chk(OFS_STATUS, 8'h01, "rst_busy", 8'h01);
    wait_out(0, 1'h0, 4200, "rst_ready");
    rd_chk(OFS_FLAG_MOD, 8'h02, "rst_flag");
    wait_out(0, 1'h1, 100, "irq_clr3");
    $display("t_modrst done");
  endtask : t_modrst

  initial begin
    repeat (5) @(negedge clk_sys);
    srst = 1'h0;
    repeat (5) @(negedge clk_sys);
    t_init;
    t_cdr;
    t_codes;
    t_flags;
    t_mask;
    t_power;
    t_select;
    t_modrst;
    stop_test;
  end
endmodule : test_module_mgmt_control_timing
